// ==== bmcs_pkg.sv ====
// package for the boot mode and clock setup block
// assumes one 100 MHz system clock and an active-low asynchronous reset
package bmcs_pkg;

	typedef enum logic [1:0] {
		BMCS_SPREAD_OFF,
		BMCS_SPREAD_NORMAL,
		BMCS_SPREAD_STRONG,
		BMCS_SPREAD_RSVD
	} bmcs_spread_e;

	typedef enum logic {
		BMCS_MODE_RUN,
		BMCS_MODE_PROGRAM
	} bmcs_mode_e;

	localparam logic [1:0] BMCS_SPREAD_RESET = 2'h1;
	localparam int unsigned BMCS_DOUBLER_FACTOR = 2;
	// crystal divider counter width: counts system cycles, wraps after DOUBLER_FACTOR
	localparam int unsigned BMCS_PHASE_W = 4;
	// address width of the erase walk, one battery RAM word per cycle
	localparam int unsigned BMCS_ERASE_ADDR_W = 10;
	// sampling settles one cycle after the synchroniser fills
	localparam int unsigned BMCS_SAMPLE_DELAY = 3;

endpackage : bmcs_pkg

// ==== bmcs_sync.sv ====
// two flip-flop synchroniser for pin levels
// assumes the pin is asynchronous to the system clock
`timescale 1ns/1ps
module bmcs_sync
	import bmcs_pkg::*;
#(
	parameter int unsigned WIDTH = 1
)(
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			meta  <= '0;
			q_out <= '0;
		end
		else
		begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule // bmcs_sync

// ==== bmcs_top.sv ====
// boot mode sampling, clock doubler control, spreader and tamper erase
// assumes pins are asynchronous; configuration inputs share SYS_CLK_IN
`timescale 1ns/1ps
module bmcs_top
	import bmcs_pkg::*;
#(
	parameter int unsigned ERASE_ADDR_W = BMCS_ERASE_ADDR_W
)(
	// clock and reset
	input  wire logic                    SYS_CLK_IN,
	input  wire logic                    RESET_N_IN,
	// board pins
	input  wire logic                    BOOT_MODE_SELECT_PINS_IN,
	input  wire logic                    BOOTSTRAP_ATTEMPT_IN,
	// configuration
	input  wire logic [1:0]              SPREAD_LEVEL_IN,
	input  wire logic                    SPREAD_LEVEL_WR_IN,
	input  wire logic                    TAMPER_ENABLE_IN,
	input  wire logic                    DOUBLER_DISABLE_REQ_IN,
	// programming port requests
	input  wire logic                    DOWNLOAD_REQ_IN,
	input  wire logic                    DEBUG_REQ_IN,
	// status
	output logic                         MODE_VALID_OUT,
	output logic                         PROGRAM_MODE_OUT,
	output logic                         RUN_MODE_OUT,
	output logic                         EXECUTE_ENABLE_OUT,
	output logic                         DOWNLOAD_GRANT_OUT,
	output logic                         DEBUG_GRANT_OUT,
	output logic                         GENERAL_INPUT_OUT,
	// clock control
	output logic                         DOUBLER_ENABLE_OUT,
	output logic                         CRYSTAL_TICK_OUT,
	output logic [1:0]                   SPREAD_LEVEL_OUT,
	// battery RAM erase
	output logic                         ERASE_BUSY_OUT,
	output logic                         ERASE_WR_OUT,
	output logic [ERASE_ADDR_W-1:0]      ERASE_ADDR_OUT,
	output logic                         ERASE_DONE_OUT
);
	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [1:0] pins_sync;

	bmcs_sync #(
		.WIDTH (2)
	) u_sync (
		.clk_in   (SYS_CLK_IN),
		.rst_n_in (RESET_N_IN),
		.d_in     ({BOOTSTRAP_ATTEMPT_IN, BOOT_MODE_SELECT_PINS_IN}),
		.q_out    (pins_sync)
	);

	logic mode_pin;
	logic boot_attempt;
	assign mode_pin     = pins_sync[0];
	assign boot_attempt = pins_sync[1];

	// ------------------------------------------------------------------
	// mode sampling after reset release
	// ------------------------------------------------------------------
	logic [1:0]  settle;
	logic        mode_valid;
	bmcs_mode_e  mode;

	// wait until the synchroniser holds a true pin level, not its reset zero
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
			settle <= 2'h0;
		else if (settle != 2'(BMCS_SAMPLE_DELAY - 1))
			settle <= settle + 2'h1;
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			mode_valid <= 1'b0;
			mode       <= BMCS_MODE_RUN;
		end
		else if (!mode_valid && settle == 2'(BMCS_SAMPLE_DELAY - 1))
		begin
			mode_valid <= 1'b1;
			// high selects program mode, low run mode
			mode <= mode_pin ? BMCS_MODE_PROGRAM : BMCS_MODE_RUN;
		end
	end

	// ------------------------------------------------------------------
	// mode status
	// ------------------------------------------------------------------
	// both mode flags stay low until the sample is taken
	function automatic logic mode_is(
		input logic       valid,
		input bmcs_mode_e cur,
		input bmcs_mode_e want
	);
		mode_is = valid && (cur == want);
	endfunction

	assign MODE_VALID_OUT   = mode_valid;
	assign PROGRAM_MODE_OUT =
		mode_is(mode_valid, mode, BMCS_MODE_PROGRAM);
	assign RUN_MODE_OUT     =
		mode_is(mode_valid, mode, BMCS_MODE_RUN);

	// ------------------------------------------------------------------
	// execution and programming port grants
	// ------------------------------------------------------------------
	// stored code is held off while battery RAM is being wiped
	assign EXECUTE_ENABLE_OUT = mode_valid && !ERASE_BUSY_OUT;
	// combinational so the host sees the grant in the cycle it asks
	assign DOWNLOAD_GRANT_OUT = PROGRAM_MODE_OUT && DOWNLOAD_REQ_IN;
	assign DEBUG_GRANT_OUT    = PROGRAM_MODE_OUT && DEBUG_REQ_IN;

	// pin level is free for software once run mode is latched
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
			GENERAL_INPUT_OUT <= 1'b0;
		else if (RUN_MODE_OUT)
			GENERAL_INPUT_OUT <= mode_pin;
	end

	// ------------------------------------------------------------------
	// clock doubler
	// ------------------------------------------------------------------
	// doubler stays on; a request to drop it is ignored by design
	assign DOUBLER_ENABLE_OUT = 1'b1;

	// crystal reference: one tick every DOUBLER_FACTOR system cycles
	logic [BMCS_PHASE_W-1:0] xtal_cnt;

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
			xtal_cnt <= '0;
		else if (xtal_cnt == BMCS_PHASE_W'(BMCS_DOUBLER_FACTOR - 1))
			xtal_cnt <= '0;
		else
			xtal_cnt <= xtal_cnt + 1'b1;
	end

	assign CRYSTAL_TICK_OUT = (xtal_cnt == '0);

	// ------------------------------------------------------------------
	// spectrum spreader level
	// ------------------------------------------------------------------
	function automatic logic [1:0] spread_legal(input logic [1:0] lvl);
		spread_legal = (lvl == BMCS_SPREAD_RSVD) ? BMCS_SPREAD_RESET : lvl;
	endfunction

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
			SPREAD_LEVEL_OUT <= BMCS_SPREAD_RESET;
		else if (SPREAD_LEVEL_WR_IN)
			// unused code 3 falls back to normal
			SPREAD_LEVEL_OUT <= spread_legal(SPREAD_LEVEL_IN);
	end

	// ------------------------------------------------------------------
	// tamper erase of battery RAM
	// ------------------------------------------------------------------
	typedef enum logic {
		ERASE_IDLE,
		ERASE_WALK
	} bmcs_erase_e;

	bmcs_erase_e             erase_state;
	logic                    attempt_d;
	logic [ERASE_ADDR_W-1:0] erase_addr;

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
			attempt_d <= 1'b0;
		else
			attempt_d <= boot_attempt;
	end

	logic attempt_rise;
	assign attempt_rise = boot_attempt && !attempt_d;

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			erase_state    <= ERASE_IDLE;
			erase_addr     <= '0;
			ERASE_DONE_OUT <= 1'b0;
		end
		else
		begin
			ERASE_DONE_OUT <= 1'b0;
			case (erase_state)
				// attempts seen during a walk are not queued
				ERASE_IDLE:
				begin
					erase_addr <= '0;
					if (attempt_rise && TAMPER_ENABLE_IN)
						erase_state <= ERASE_WALK;
				end
				ERASE_WALK:
				begin
					erase_addr <= erase_addr + 1'b1;
					if (erase_addr == '1)
					begin
						erase_state    <= ERASE_IDLE;
						ERASE_DONE_OUT <= 1'b1;
					end
				end
				default:
					erase_state <= ERASE_IDLE;
			endcase
		end
	end

	assign ERASE_BUSY_OUT = (erase_state == ERASE_WALK);

	// one zero write per cycle while busy
	assign ERASE_WR_OUT   = ERASE_BUSY_OUT;
	assign ERASE_ADDR_OUT = erase_addr;

endmodule // bmcs_top

// ==== bmcs_chk.sv ====
// assertions on the ports of bmcs_top
// bound to bmcs_top from the testbench
`timescale 1ns/1ps
module bmcs_chk
	import bmcs_pkg::*;
#(
	parameter int unsigned ERASE_ADDR_W = BMCS_ERASE_ADDR_W
)(
	// clock and reset
	input wire logic			SYS_CLK_IN,
	input wire logic			RESET_N_IN,
	// inputs
	input wire logic [1:0]			SPREAD_LEVEL_IN,
	input wire logic			SPREAD_LEVEL_WR_IN,
	input wire logic			DOWNLOAD_REQ_IN,
	// outputs
	input wire logic			MODE_VALID_OUT,
	input wire logic			PROGRAM_MODE_OUT,
	input wire logic			RUN_MODE_OUT,
	input wire logic			EXECUTE_ENABLE_OUT,
	input wire logic			DOWNLOAD_GRANT_OUT,
	input wire logic			DOUBLER_ENABLE_OUT,
	input wire logic			CRYSTAL_TICK_OUT,
	input wire logic [1:0]			SPREAD_LEVEL_OUT,
	input wire logic			ERASE_BUSY_OUT,
	input wire logic [ERASE_ADDR_W-1:0]	ERASE_ADDR_OUT,
	input wire logic			ERASE_DONE_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	property p_mode; (PROGRAM_MODE_OUT | RUN_MODE_OUT) == MODE_VALID_OUT
		&& !(PROGRAM_MODE_OUT && RUN_MODE_OUT); endproperty
	a_mode: assert property (p_mode) else $error("bad mode");
	property p_hold; MODE_VALID_OUT |=> MODE_VALID_OUT
		&& $stable(PROGRAM_MODE_OUT); endproperty
	a_hold: assert property (p_hold) else $error("mode moved");
	property p_grant; DOWNLOAD_GRANT_OUT
		== (PROGRAM_MODE_OUT && DOWNLOAD_REQ_IN); endproperty
	a_grant: assert property (p_grant) else $error("bad grant");
	property p_exec; EXECUTE_ENABLE_OUT
		== (MODE_VALID_OUT && !ERASE_BUSY_OUT); endproperty
	a_exec: assert property (p_exec) else $error("bad execute");
	property p_tick; !CRYSTAL_TICK_OUT |=> CRYSTAL_TICK_OUT
		&& DOUBLER_ENABLE_OUT ##1 !CRYSTAL_TICK_OUT; endproperty
	a_tick: assert property (p_tick) else $error("bad tick");
	property p_spr_wr; SPREAD_LEVEL_WR_IN |=> SPREAD_LEVEL_OUT ==
		($past(SPREAD_LEVEL_IN) == 2'h3 ? 2'h1 : $past(SPREAD_LEVEL_IN));
	endproperty
	a_spr_wr: assert property (p_spr_wr) else $error("bad level");
	property p_spr_hold; !SPREAD_LEVEL_WR_IN |=> $stable(SPREAD_LEVEL_OUT);
	endproperty
	a_spr_hold: assert property (p_spr_hold) else $error("level moved");
	property p_er_go; $rose(ERASE_BUSY_OUT) |-> ERASE_ADDR_OUT == '0;
	endproperty
	a_er_go: assert property (p_er_go) else $error("bad first addr");
	property p_er_end; ERASE_BUSY_OUT && (&ERASE_ADDR_OUT) |=>
		ERASE_DONE_OUT && !ERASE_BUSY_OUT; endproperty
	a_er_end: assert property (p_er_end) else $error("bad erase end");
endmodule // bmcs_chk

// ==== bmcs_board.sv ====
// board strapping jumper and bootstrap attempt line
// drives only on falling edges of the system clock
`timescale 1ns/1ps
module bmcs_board(
	// clock
	input wire logic	clk_in,
	// pins
	output logic		mode_pins_out,
	output logic		attempt_out
);
	initial mode_pins_out = 1'h1;
	initial attempt_out = 1'h0;
	// jumper kept steady through reset release
	task automatic strap(input logic v);
		@(negedge clk_in);
		mode_pins_out = v;
	endtask
	task automatic attempt(input int n);
		@(negedge clk_in);
		attempt_out = 1'h1;
		repeat (n) @(negedge clk_in);
		attempt_out = 1'h0;
	endtask
endmodule // bmcs_board

// ==== tb.sv ====
// self-checking bench for bmcs_top
// board model drives the pins, bench drives configuration
`timescale 1ns/1ps
module tb;
	import bmcs_pkg::*;
	logic		clk = 1'h0, rst_n = 1'h0, wr = 1'h0, ten = 1'h0;
	logic		dl = 1'h0, dbg = 1'h0, val, prg, run, exe, dlg, dbgg;
	logic		gin, den, tick, busy, ewr, done, ddis = 1'h0;
	logic [1:0]	lvl = 2'h0, lvo;
	logic [2:0]	addr;
	wire logic	pins, att;
	int		n_errors = 0, total_checks = 0, cyc = 0, k;
	always #5 clk = ~clk;
	bmcs_board bmcs_board_inst(.clk_in(clk), .mode_pins_out(pins),
		.attempt_out(att));
	bmcs_top #(.ERASE_ADDR_W(3)) bmcs_top_inst(.SYS_CLK_IN(clk),
		.RESET_N_IN(rst_n), .BOOT_MODE_SELECT_PINS_IN(pins),
		.BOOTSTRAP_ATTEMPT_IN(att), .SPREAD_LEVEL_IN(lvl),
		.SPREAD_LEVEL_WR_IN(wr), .TAMPER_ENABLE_IN(ten),
		.DOUBLER_DISABLE_REQ_IN(ddis),
		.DOWNLOAD_REQ_IN(dl), .DEBUG_REQ_IN(dbg), .MODE_VALID_OUT(val),
		.PROGRAM_MODE_OUT(prg), .RUN_MODE_OUT(run),
		.EXECUTE_ENABLE_OUT(exe), .DOWNLOAD_GRANT_OUT(dlg),
		.DEBUG_GRANT_OUT(dbgg), .GENERAL_INPUT_OUT(gin),
		.DOUBLER_ENABLE_OUT(den), .CRYSTAL_TICK_OUT(tick),
		.SPREAD_LEVEL_OUT(lvo), .ERASE_BUSY_OUT(busy), .ERASE_WR_OUT(ewr),
		.ERASE_ADDR_OUT(addr), .ERASE_DONE_OUT(done));
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic boot(input logic v);
		bmcs_board_inst.strap(v);
		rst_n = 1'h0;
		repeat (4) @(negedge clk);
		rst_n = 1'h1;
		repeat (2) @(negedge clk);
		chk(val, 10'h0);
		@(negedge clk);
		chk({val, prg, run}, {7'h0, 1'h1, v, !v});
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	// hang guard far above the under one hundred cycles needed
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_errors++;
			summarize();
		end
	end
	initial
	begin
		boot(1'h1);
		chk({lvo, den, exe}, 10'h7);
		// a request to drop the doubler must be refused
		ddis = 1'h1;
		wait_n(2);
		chk(den, 10'h1);
		ddis = 1'h0;
		for (k = 0; k < 4; k++)
		begin
			dl = k[0];
			dbg = k[1];
			#1 chk({dlg, dbgg}, {8'h0, k[0], k[1]});
			@(negedge clk);
		end
		bmcs_board_inst.strap(1'h0);
		wait_n(5);
		chk({prg, run, gin}, 10'h4);
		boot(1'h0);
		chk({dlg, dbgg, exe}, 10'h1);
		bmcs_board_inst.strap(1'h1);
		wait_n(4);
		chk({run, gin}, 10'h3);
		wr = 1'h1;
		for (k = 0; k < 4; k++)
		begin
			lvl = k[1:0];
			@(negedge clk);
			chk(lvo, (k == 3) ? 10'h1 : k[9:0]);
		end
		wr = 1'h0;
		@(negedge clk);
		chk(lvo, 10'h1);
		ten = 1'h1;
		fork bmcs_board_inst.attempt(20); join_none
		for (k = 0; k < 8 && !busy; k++) @(negedge clk);
		chk(busy, 10'h1);
		for (k = 0; k < 12 && busy; k++)
		begin
			chk({exe, ewr, addr}, {5'h0, 1'h0, 1'h1, k[2:0]});
			@(negedge clk);
		end
		chk({k[8:0], done}, {9'h8, 1'h1});
		wait_n(14);
		chk({busy, exe}, 10'h1);
		ten = 1'h0;
		fork bmcs_board_inst.attempt(3); join_none
		wait_n(10);
		chk(busy, 10'h0);
		summarize();
	end
endmodule // tb
bind bmcs_top bmcs_chk #(.ERASE_ADDR_W(ERASE_ADDR_W)) bmcs_chk_inst(
	.SYS_CLK_IN, .RESET_N_IN, .SPREAD_LEVEL_IN, .SPREAD_LEVEL_WR_IN,
	.DOWNLOAD_REQ_IN, .MODE_VALID_OUT, .PROGRAM_MODE_OUT, .RUN_MODE_OUT,
	.EXECUTE_ENABLE_OUT, .DOWNLOAD_GRANT_OUT, .DOUBLER_ENABLE_OUT,
	.CRYSTAL_TICK_OUT, .SPREAD_LEVEL_OUT, .ERASE_BUSY_OUT,
	.ERASE_ADDR_OUT, .ERASE_DONE_OUT);
